/* File: dv/kbi_kbd_model.sv */
// Behavioural serial keyboard on the far side of the clock and data pins.
// Assumes the bench resolves both open-collector lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module kbi_kbd_model (
	// Resolved line levels.
	input  wire logic clk_w_i,
	input  wire logic data_w_i,
	// Pull-low drives.
	output logic      clk_low_o,
	output logic      data_low_o
);
	// ****************************************************************
	// Frame sender
	// ****************************************************************
	// Both lines rest released, so the clock stands high between frames.
	initial begin
		clk_low_o  = 1'b0;
		data_low_o = 1'b0;
	end

	// High start bit, then the code LSB first, one clock pulse per bit.
	task automatic send(input logic [7:0] code);
		logic [8:0] f;
		f = {code, 1'b1};
		wait (clk_w_i && data_w_i); // Hold off while the device inhibits us.
		for (int i = 0; i < 9; i++) begin
			data_low_o = ~f[i];
			#40 clk_low_o = 1'b1;
			#40 clk_low_o = 1'b0;
		end
		#40 data_low_o = 1'b0;
	endtask
endmodule // kbi_kbd_model

`default_nettype wire

/* File: dv/kbi_top_chk.sv */
// Port-level assertions for the keyboard port block.
// Assumes config shadows track writes made through the index port.
`timescale 1ns/1ps
`default_nettype none

module kbi_top_chk (
	// Clock and reset.
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	// Requests.
	input  wire kbi_pkg::kbi_cfg_req_t cfg_i,
	input  wire logic                  io_valid_i,
	input  wire kbi_pkg::kbi_io_req_t  io_req_i,
	// Outputs watched.
	input  wire logic                  io_done_o,
	input  wire logic                  xbus_rd_n_o,
	input  wire logic                  xbus_wr_n_o,
	input  wire logic                  kbd_sel_data_o,
	input  wire logic                  kbd_sel_data_oe_o,
	input  wire logic                  kbd_clock_pin_oe_o,
	input  wire logic                  kbd_irq_o
);
	logic       mode, clr, hold, busy, port, strb;
	logic [1:0] dly;
	logic [2:0] ws;
	logic [4:0] cnt, lat;
	logic [3:0] low;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ****************************************************************
	// Helper shadows
	// ****************************************************************
	// Only 60H and 64H count as keyboard requests.
	assign port = io_valid_i && (io_req_i.addr == kbi_pkg::DATA_PORT ||
		io_req_i.addr == kbi_pkg::CTRL_PORT);
	assign strb = xbus_rd_n_o && xbus_wr_n_o;
	assign lat  = 5'(dly) + 5'(ws) + 5'd4;

	// Shadow the mode, timing and control bits as software writes them.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			{mode, clr, hold} <= 3'b000;
			dly <= 2'(kbi_pkg::CMD_DELAY_RST);
			ws <= 3'(kbi_pkg::WAIT_STATE_RST);
		end else begin
			if (cfg_i.wr && cfg_i.index == kbi_pkg::PERIPH_SEL_IDX) mode <= cfg_i.wdata[2];
			if (cfg_i.wr && cfg_i.index == kbi_pkg::CMD_DELAY_IDX) dly <= cfg_i.wdata[1:0];
			if (cfg_i.wr && cfg_i.index == kbi_pkg::WAIT_STATE_IDX) ws <= cfg_i.wdata[2:0];
			if (mode && port && io_req_i.write && io_req_i.addr == kbi_pkg::CTRL_PORT)
				{clr, hold} <= io_req_i.wdata[7:6];
		end
	end

	// Cycle count since a parallel request was taken.
	always_ff @(posedge clk_i) begin
		if (!resetn_i || io_done_o) begin
			busy <= 1'b0;
			cnt <= 5'd0;
		end else if (port && !mode && !busy) begin
			busy <= 1'b1;
			cnt <= 5'd1;
		end else if (busy) cnt <= cnt + 5'd1;
	end

	// Length of the current strobe-low run.
	always_ff @(posedge clk_i) low <= (!resetn_i || strb) ? 4'd0 : low + 4'd1;

	sequence s_par_take; port && !mode && !busy; endsequence
	sequence s_ser_take; port && mode; endsequence

	a_par_done_at: assert property (io_done_o && !mode |-> busy && cnt == lat)
		else $error("parallel answer off count");
	a_par_due: assert property (busy && !mode && cnt == lat |-> io_done_o)
		else $error("parallel answer missing");
	a_sel_low_span: assert property (busy && !mode && cnt >= 2 && cnt < lat |-> !kbd_sel_data_o)
		else $error("select not low in cycle");
	a_sel_from_take: assert property (s_par_take |=> ##1 !kbd_sel_data_o)
		else $error("select late");
	a_strobe_width: assert property ($rose(strb) && !mode |-> low == 4'(ws) + 4'd1)
		else $error("strobe width wrong");
	a_recovery_clock: assert property ($rose(strb) && !mode |=> io_done_o)
		else $error("recovery clock wrong");
	a_ser_no_bus: assert property (mode |-> strb)
		else $error("bus strobe in serial mode");
	a_ser_done_next: assert property (s_ser_take |=> io_done_o)
		else $error("serial answer late");
	a_clk_pull_low: assert property ((mode && !hold)[*2] |-> kbd_clock_pin_oe_o)
		else $error("clock not pulled low");
	a_clk_released: assert property ((mode && hold)[*2] |-> !kbd_clock_pin_oe_o)
		else $error("clock not released");
	a_clear_idles: assert property ((mode && clr)[*2] |-> !kbd_irq_o && !kbd_sel_data_oe_o)
		else $error("clear left irq or data low");
	a_irq_holds_data: assert property (mode && kbd_irq_o && $past(kbd_irq_o) |-> kbd_sel_data_oe_o)
		else $error("data not held low with irq");
endmodule // kbi_top_chk

bind kbi_top kbi_top_chk u_chk (.*);

`default_nettype wire

/* File: dv/kbi_top_test.sv */
// Self-checking bench for the keyboard port block, both modes.
// Assumes the keyboard model and the checker sit beside the design.
`timescale 1ns/1ps
`default_nettype none

module kbi_top_test;
	logic                  clk_i, resetn_i, io_valid_i, io_done_o, a2v, kb_cl, kb_dl;
	kbi_pkg::kbi_cfg_req_t cfg_i;
	kbi_pkg::kbi_io_req_t  io_req_i;
	logic [7:0]            cfg_rdata_o, io_rdata_o, xbus_wdata_o, xbus_rdata_i, rdv, wdv;
	logic                  xbus_rd_n_o, xbus_wr_n_o, xbus_a2_o, xbus_wdata_oe_o;
	logic                  kbd_sel_data_i, kbd_sel_data_o, kbd_sel_data_oe_o;
	logic                  kbd_clock_pin_i, kbd_clock_pin_o, kbd_clock_pin_oe_o;
	logic                  kbd_ctrl_reset_n_o, kbd_irq_in_i, addr20_gate_i, cpu_only_reset_n_i;
	logic                  kbd_irq_o, addr20_gate_o, cpu_only_reset_req_o;
	logic [31:0]           lfsr, r;
	int                    err_count, n_tests, lat;
	logic [7:0]            ri[4] = '{8'h03, 8'h04, 8'h05, 8'h07};
	logic [7:0]            rv[4] = '{kbi_pkg::PERIPH_SEL_RST, kbi_pkg::CMD_DELAY_RST,
		kbi_pkg::WAIT_STATE_RST, 8'h00};

	// ****************************************************************
	// Harness
	// ****************************************************************
	// Wired-AND of both parties on each open-collector pin, pull-up high.
	assign kbd_sel_data_i  = ~((kbd_sel_data_oe_o & ~kbd_sel_data_o) | kb_dl);
	assign kbd_clock_pin_i = ~((kbd_clock_pin_oe_o & ~kbd_clock_pin_o) | kb_cl);
	kbi_top #(.KCLK_BASE_DIV(2)) dut (.*);
	kbi_kbd_model u_kbd (.clk_w_i(kbd_clock_pin_i), .data_w_i(kbd_sel_data_i),
		.clk_low_o(kb_cl), .data_low_o(kb_dl));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// The whole run needs about 6 us; a hang ends it well after that.
	initial begin
		#200000;
		err_count++;
		test_done();
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(negedge clk_i);
		cfg_i = '{wr: wr, rd: ~wr, index: idx, wdata: wd};
		@(negedge clk_i);
		cfg_i = '0;
	endtask

	// One request; lat counts edges to the answer, strobe-time bus values kept.
	task automatic io(input logic wr, input logic [15:0] ad, input logic [7:0] wd);
		@(negedge clk_i);
		io_valid_i = 1'b1;
		io_req_i = '{write: wr, addr: ad, wdata: wd};
		{a2v, wdv} = 9'bx;
		@(negedge clk_i);
		io_valid_i = 1'b0;
		for (lat = 1; io_done_o !== 1'b1 && lat < 40; lat++) begin
			if (!xbus_rd_n_o || !xbus_wr_n_o)
				{a2v, wdv} = {xbus_a2_o, xbus_wdata_oe_o ? xbus_wdata_o : 8'hXX};
			@(negedge clk_i);
		end
		rdv = io_rdata_o;
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{lfsr, err_count, n_tests, resetn_i, io_valid_i} = {32'hFBD2, 64'h0, 2'b00};
		{cfg_i, io_req_i, xbus_rdata_i} = '0;
		{kbd_irq_in_i, addr20_gate_i, cpu_only_reset_n_i} = 3'b001;
		repeat (16) @(negedge clk_i);
		resetn_i = 1'b1;
		foreach (ri[k]) begin
			cfg(1'b0, ri[k], 8'h00);
			chk8("cfg reset", rv[k], cfg_rdata_o);
		end
		chk8("ctrl pins", 8'h03, {6'h0, kbd_ctrl_reset_n_o, kbd_sel_data_o});
		{kbd_irq_in_i, addr20_gate_i, cpu_only_reset_n_i} = 3'b110;
		repeat (4) @(negedge clk_i);
		chk8("returns", 8'h07, {5'h0, kbd_irq_o, addr20_gate_o, cpu_only_reset_req_o});
		cpu_only_reset_n_i = 1'b1;
		addr20_gate_i = 1'b0;
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			if (k < 2) r[4:0] = {5{k[0]}};
			cfg(1'b1, 8'h04, {6'h0, r[4:3]});
			cfg(1'b1, 8'h05, {5'h0, r[2:0]});
			xbus_rdata_i = r[15:8];
			io(r[16], r[17] ? 16'h0064 : 16'h0060, r[31:24]);
			xbus_rdata_i = ~r[15:8];
			chk8("par latency", 8'(r[4:3] + r[2:0] + 4), 8'(lat));
			chk8("par a2", {7'h0, r[17]}, {7'h0, a2v});
			chk8("par data", r[16] ? r[31:24] : r[15:8], r[16] ? wdv : rdv);
		end
		// Pin toggles over 64 clocks, full rate then divided.
		for (int s = 0; s < 2; s++) begin
			cfg(1'b1, 8'h03, {4'h0, s[0], 3'h0});
			repeat (40) @(negedge clk_i);
			lat = 0;
			repeat (64) begin
				a2v = kbd_clock_pin_o;
				@(negedge clk_i);
				lat += int'(a2v !== kbd_clock_pin_o);
			end
			chk8("kclk rate", 8'(64 / (s ? 2 * kbi_pkg::SLOW_CLK_DIVISOR : 2)), 8'(lat));
		end
		cfg(1'b1, 8'h03, 8'h04);
		repeat (3) @(negedge clk_i);
		chk8("clk held", 8'h01, {7'h0, kbd_clock_pin_oe_o});
		{addr20_gate_i, cpu_only_reset_n_i} = 2'h2;
		io(1'b1, 16'h0064, 8'hC0);
		io(1'b1, 16'h0064, 8'h40);
		io(1'b0, 16'h0064, 8'h00);
		chk8("ctrl port", 8'h40, rdv);
		chk8("ser latency", 8'h01, 8'(lat));
		chk8("irq ignored", 8'h00, {5'h0, kbd_irq_o, addr20_gate_o, cpu_only_reset_req_o});
		for (int k = 0; k < 5; k++) begin
			r = rnd();
			if (k < 2) r[7:0] = {8{k[0]}};
			u_kbd.send(r[7:0]);
			for (lat = 0; kbd_irq_o !== 1'b1 && lat < 50; lat++) @(negedge clk_i);
			io(1'b1, 16'h0060, ~r[7:0]);
			io(1'b0, 16'h0060, 8'h00);
			chk8("scan code", r[7:0], rdv);
			chk8("irq hold", 8'h03, {6'h0, kbd_irq_o, kbd_sel_data_oe_o});
			io(1'b1, 16'h0064, 8'hC0);
			repeat (2) @(negedge clk_i);
			io(1'b0, 16'h0060, 8'h00);
			chk8("cleared", 8'h00, rdv);
			chk8("irq drop", 8'h00, {6'h0, kbd_irq_o, kbd_sel_data_oe_o});
			io(1'b1, 16'h0064, 8'h40);
		end
		test_done();
	end
endmodule // kbi_top_test

`default_nettype wire

/* File: verilog/kbi_clk_div.sv */
// Enable-pulse divider that paces the keyboard clock output.
// Assumes the caller toggles its own output flop on each tick.
`timescale 1ns/1ps
`default_nettype none

module kbi_clk_div #(
	parameter int BASE_DIV = 8
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Control and tick.
	input  wire logic slow_i,
	output logic      tick_o
);

	localparam int CW = $clog2(BASE_DIV * kbi_pkg::SLOW_CLK_DIVISOR);
	localparam logic [CW-1:0] LIM_FAST = CW'(BASE_DIV - 1);
	localparam logic [CW-1:0] LIM_SLOW = CW'(BASE_DIV * kbi_pkg::SLOW_CLK_DIVISOR - 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] lim;

	// The low-power setting stretches the period sixteenfold.
	assign lim = slow_i ? LIM_SLOW : LIM_FAST;

	// Free-running count; a switch of rate applies at once to the period under way.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (cnt_reg >= lim) begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end

endmodule // kbi_clk_div

`default_nettype wire

/* File: verilog/kbi_pkg.sv */
// Constants, field layouts and carrier types for the keyboard port block.
// Assumes a single 250 MHz core clock and a synchronous active-low reset.
`default_nettype none

package kbi_pkg;

	// ****************************************************************
	// Configuration register indices and fields
	// ****************************************************************
	localparam logic [7:0] PERIPH_SEL_IDX  = 8'h03;
	localparam logic [7:0] CMD_DELAY_IDX   = 8'h04;
	localparam logic [7:0] WAIT_STATE_IDX  = 8'h05;
	localparam int         MODE_SEL_BIT    = 2;    // Serial keyboard mode select.
	localparam int         CLK_SLOW_BIT    = 3;    // Keyboard clock divide by 16.
	localparam int         CMD_DLY_LSB     = 0;    // 8-bit I/O command delay field.
	localparam int         CMD_DLY_W       = 2;
	localparam int         WAIT_ST_LSB     = 0;    // 8-bit I/O wait state field.
	localparam int         WAIT_ST_W       = 3;
	localparam logic [7:0] PERIPH_SEL_RST  = 8'h00;
	localparam logic [7:0] CMD_DELAY_RST   = 8'h01;
	localparam logic [7:0] WAIT_STATE_RST  = 8'h01;

	// ****************************************************************
	// CPU I/O ports and the serial control port layout
	// ****************************************************************
	localparam logic [15:0] DATA_PORT      = 16'h0060;
	localparam logic [15:0] CTRL_PORT      = 16'h0064;
	localparam int          SCAN_CLEAR_BIT = 7;
	localparam int          CLK_HOLD_BIT   = 6;
	localparam logic        CTRL_BIT_RST   = 1'b0;
	localparam logic [7:0]  SCAN_CODE_RST  = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS     = 4;
	localparam int RECOVERY_CYCLES   = 1;    // Extra data recovery clock per cycle.
	localparam int SLOW_CLK_DIVISOR  = 16;
	localparam int SCAN_BITS         = 8;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} kbi_io_req_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} kbi_cfg_req_t;

endpackage

`default_nettype wire

/* File: verilog/kbi_serial_rx.sv */
// Serial scan code receiver for a directly attached keyboard.
// Assumes clock and data pins are open-collector levels read as plain inputs.
`timescale 1ns/1ps
`default_nettype none

module kbi_serial_rx (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Control.
	input  wire logic       enable_i,
	input  wire logic       arm_i,
	// Keyboard lines.
	input  wire logic       kbd_clk_i,
	input  wire logic       kbd_data_i,
	// Result.
	output logic [7:0]      code_o,
	output logic            full_o
);

	typedef enum logic [1:0] {RX_START, RX_DATA, RX_FULL} kbi_rx_state_t;

	logic          clk_s1_reg;
	logic          clk_s2_reg;
	logic          clk_s3_reg;
	logic          dat_s1_reg;
	logic          dat_s2_reg;
	logic          fall;
	logic [2:0]    bit_reg;
	logic [7:0]    shift_reg;
	kbi_rx_state_t state_reg;

	// ****************************************************************
	// Synchronisers and edge detect
	// ****************************************************************
	// Two flops on data, three on clock; the edge detector only looks at stage two onward.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			clk_s1_reg <= 1'b1;
			clk_s2_reg <= 1'b1;
			clk_s3_reg <= 1'b1;
			dat_s1_reg <= 1'b1;
			dat_s2_reg <= 1'b1;
		end else begin
			clk_s1_reg <= kbd_clk_i;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			dat_s1_reg <= kbd_data_i;
			dat_s2_reg <= dat_s1_reg;
		end
	end

	// Data is taken on the falling edge of each clock pulse.
	assign fall = clk_s3_reg & ~clk_s2_reg;

	// ****************************************************************
	// Receive sequence
	// ****************************************************************
	// Arming discards the held code and waits for a new start bit.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_reg <= RX_START;
			bit_reg   <= '0;
			shift_reg <= kbi_pkg::SCAN_CODE_RST;
			code_o    <= kbi_pkg::SCAN_CODE_RST;
			full_o    <= 1'b0;
		end else if (!enable_i || arm_i) begin
			state_reg <= RX_START;
			bit_reg   <= '0;
			code_o    <= kbi_pkg::SCAN_CODE_RST;
			full_o    <= 1'b0;
		end else if (fall) begin
			unique case (state_reg)
				RX_START: begin
					if (dat_s2_reg) begin
						state_reg <= RX_DATA;
						bit_reg   <= '0;
					end
				end
				RX_DATA: begin
					shift_reg <= {dat_s2_reg, shift_reg[7:1]};
					bit_reg   <= bit_reg + 1'b1;
					if (bit_reg == 3'(kbi_pkg::SCAN_BITS - 1)) begin
						state_reg <= RX_FULL;
						code_o    <= {dat_s2_reg, shift_reg[7:1]};
						full_o    <= 1'b1;
					end
				end
				RX_FULL: state_reg <= RX_FULL;
			endcase
		end
	end

endmodule // kbi_serial_rx

`default_nettype wire

/* File: verilog/kbi_top.sv */
// Keyboard port logic: parallel controller interface or serial keyboard.
// Assumes CPU I/O requests arrive one at a time and wait for io_done_o.
`timescale 1ns/1ps
`default_nettype none

module kbi_top #(
	parameter int KCLK_BASE_DIV = 8
) (
	// Clock and power-good reset.
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	// Configuration index port.
	input  wire kbi_pkg::kbi_cfg_req_t cfg_i,
	output logic [7:0]                cfg_rdata_o,
	// CPU I/O port requests.
	input  wire logic                 io_valid_i,
	input  wire kbi_pkg::kbi_io_req_t io_req_i,
	output logic [7:0]                io_rdata_o,
	output logic                      io_done_o,
	// Peripheral expansion bus.
	output logic                      xbus_rd_n_o,
	output logic                      xbus_wr_n_o,
	output logic                      xbus_a2_o,
	output logic [7:0]                xbus_wdata_o,
	output logic                      xbus_wdata_oe_o,
	input  wire logic [7:0]           xbus_rdata_i,
	// Select pin, serial data line in serial mode.
	input  wire logic                 kbd_sel_data_i,
	output logic                      kbd_sel_data_o,
	output logic                      kbd_sel_data_oe_o,
	// Clock pin, serial clock line in serial mode.
	input  wire logic                 kbd_clock_pin_i,
	output logic                      kbd_clock_pin_o,
	output logic                      kbd_clock_pin_oe_o,
	// Controller side signals.
	output logic                      kbd_ctrl_reset_n_o,
	input  wire logic                 kbd_irq_in_i,
	input  wire logic                 addr20_gate_i,
	input  wire logic                 cpu_only_reset_n_i,
	// To the system.
	output logic                      kbd_irq_o,
	output logic                      addr20_gate_o,
	output logic                      cpu_only_reset_req_o
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum logic [2:0] {
		CYC_IDLE, CYC_DELAY, CYC_ACTIVE, CYC_RECOVER, CYC_DONE
	} kbi_cyc_state_t;

	logic [7:0]             periph_select_reg;
	logic [7:0]             command_delay_reg;
	logic [7:0]             wait_state_reg;
	logic                   scan_clear_bit_reg;
	logic                   clock_hold_bit_reg;
	logic                   serial_kbd_mode_sel;
	logic                   kclk_slow;
	logic                   kclk_tick;
	logic                   kclk_reg;
	logic [7:0]             scan_code;
	logic                   scan_full;
	logic                   port_hit;
	logic                   serial_req;
	logic                   par_req;
	kbi_cyc_state_t         cyc_state_reg;
	logic [3:0]             cyc_cnt_reg;
	logic                   cyc_write_reg;
	logic [7:0]             rdata_next;
	logic                   sel_data_next;
	logic                   sel_data_oe_next;
	logic                   clk_pin_next;
	logic                   clk_pin_oe_next;

	assign serial_kbd_mode_sel = periph_select_reg[kbi_pkg::MODE_SEL_BIT];
	assign kclk_slow           = periph_select_reg[kbi_pkg::CLK_SLOW_BIT];
	assign port_hit   = (io_req_i.addr == kbi_pkg::DATA_PORT) ||
	                    (io_req_i.addr == kbi_pkg::CTRL_PORT);
	assign serial_req = io_valid_i && port_hit && serial_kbd_mode_sel;
	assign par_req    = io_valid_i && port_hit && !serial_kbd_mode_sel &&
	                    (cyc_state_reg == CYC_IDLE);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Written by index; a mode change mid-cycle is the software's hazard.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			periph_select_reg <= kbi_pkg::PERIPH_SEL_RST;
			command_delay_reg <= kbi_pkg::CMD_DELAY_RST;
			wait_state_reg    <= kbi_pkg::WAIT_STATE_RST;
		end else if (cfg_i.wr) begin
			if (cfg_i.index == kbi_pkg::PERIPH_SEL_IDX)
				periph_select_reg <= cfg_i.wdata;
			if (cfg_i.index == kbi_pkg::CMD_DELAY_IDX)
				command_delay_reg <= cfg_i.wdata;
			if (cfg_i.index == kbi_pkg::WAIT_STATE_IDX)
				wait_state_reg <= cfg_i.wdata;
		end
	end

	// Index reads return the stored value; unknown indices read zero.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg_rdata_o <= 8'h00;
		end else if (cfg_i.rd) begin
			unique case (cfg_i.index)
				kbi_pkg::PERIPH_SEL_IDX: cfg_rdata_o <= periph_select_reg;
				kbi_pkg::CMD_DELAY_IDX:  cfg_rdata_o <= command_delay_reg;
				kbi_pkg::WAIT_STATE_IDX: cfg_rdata_o <= wait_state_reg;
				default:                 cfg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Serial control port
	// ****************************************************************
	// Only bits 7 and 6 are stored; the other bits read as zero.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scan_clear_bit_reg <= kbi_pkg::CTRL_BIT_RST;
			clock_hold_bit_reg <= kbi_pkg::CTRL_BIT_RST;
		end else if (serial_req && io_req_i.write &&
		             io_req_i.addr == kbi_pkg::CTRL_PORT) begin
			scan_clear_bit_reg <= io_req_i.wdata[kbi_pkg::SCAN_CLEAR_BIT];
			clock_hold_bit_reg <= io_req_i.wdata[kbi_pkg::CLK_HOLD_BIT];
		end
	end

	// ****************************************************************
	// Serial receiver and clock divider
	// ****************************************************************
	kbi_serial_rx u_rx (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.enable_i   (serial_kbd_mode_sel),
		.arm_i      (scan_clear_bit_reg),
		.kbd_clk_i  (kbd_clock_pin_i),
		.kbd_data_i (kbd_sel_data_i),
		.code_o     (scan_code),
		.full_o     (scan_full)
	);

	kbi_clk_div #(
		.BASE_DIV (KCLK_BASE_DIV)
	) u_div (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.slow_i   (kclk_slow),
		.tick_o   (kclk_tick)
	);

	// The square wave runs in both modes but reaches the clock pin only in parallel mode.
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			kclk_reg <= 1'b0;
		else if (kclk_tick)
			kclk_reg <= ~kclk_reg;
	end

	// ****************************************************************
	// Parallel bus cycle sequencer
	// ****************************************************************
	// Delay, then strobe for wait states plus one, then one recovery clock.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cyc_state_reg <= CYC_IDLE;
			cyc_cnt_reg   <= '0;
			cyc_write_reg <= 1'b0;
			xbus_a2_o     <= 1'b0;
			xbus_wdata_o  <= 8'h00;
		end else begin
			unique case (cyc_state_reg)
				CYC_IDLE: begin
					if (par_req) begin
						cyc_state_reg <= CYC_DELAY;
						cyc_cnt_reg   <= 4'(command_delay_reg[kbi_pkg::CMD_DLY_LSB +:
						                    kbi_pkg::CMD_DLY_W]);
						cyc_write_reg <= io_req_i.write;
						xbus_a2_o     <= io_req_i.addr[2];
						xbus_wdata_o  <= io_req_i.wdata;
					end
				end
				CYC_DELAY: begin
					if (cyc_cnt_reg == 4'h0) begin
						cyc_state_reg <= CYC_ACTIVE;
						cyc_cnt_reg   <= 4'(wait_state_reg[kbi_pkg::WAIT_ST_LSB +:
						                    kbi_pkg::WAIT_ST_W]);
					end else begin
						cyc_cnt_reg <= cyc_cnt_reg - 4'h1;
					end
				end
				CYC_ACTIVE: begin
					if (cyc_cnt_reg == 4'h0) begin
						cyc_state_reg <= CYC_RECOVER;
						cyc_cnt_reg   <= 4'(kbi_pkg::RECOVERY_CYCLES - 1);
					end else begin
						cyc_cnt_reg <= cyc_cnt_reg - 4'h1;
					end
				end
				CYC_RECOVER: begin
					if (cyc_cnt_reg == 4'h0)
						cyc_state_reg <= CYC_DONE;
					else
						cyc_cnt_reg <= cyc_cnt_reg - 4'h1;
				end
				CYC_DONE: cyc_state_reg <= CYC_IDLE;
			endcase
		end
	end

	// Bus strobes; the select stays low from delay through the strobe and the recovery clock.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			xbus_rd_n_o     <= 1'b1;
			xbus_wr_n_o     <= 1'b1;
			xbus_wdata_oe_o <= 1'b0;
		end else begin
			xbus_rd_n_o     <= !(cyc_state_reg == CYC_DELAY && cyc_cnt_reg == 4'h0 &&
			                     !cyc_write_reg) &&
			                   !(cyc_state_reg == CYC_ACTIVE && cyc_cnt_reg != 4'h0 &&
			                     !cyc_write_reg);
			xbus_wr_n_o     <= !(cyc_state_reg == CYC_DELAY && cyc_cnt_reg == 4'h0 &&
			                     cyc_write_reg) &&
			                   !(cyc_state_reg == CYC_ACTIVE && cyc_cnt_reg != 4'h0 &&
			                     cyc_write_reg);
			xbus_wdata_oe_o <= cyc_write_reg &&
			                   (cyc_state_reg == CYC_DELAY || cyc_state_reg == CYC_ACTIVE);
		end
	end

	// ****************************************************************
	// CPU answer
	// ****************************************************************
	// Serial ports answer in one clock, parallel ones after the bus cycle.
	always_comb begin
		rdata_next = io_rdata_o;
		if (serial_req && !io_req_i.write) begin
			if (io_req_i.addr == kbi_pkg::DATA_PORT)
				rdata_next = scan_code;
			else
				rdata_next = {scan_clear_bit_reg, clock_hold_bit_reg, 6'h00};
		end else if (cyc_state_reg == CYC_ACTIVE && cyc_cnt_reg == 4'h0 &&
		             !cyc_write_reg) begin
			rdata_next = xbus_rdata_i;
		end
	end

	// Writes to the read-only scan code port are accepted and dropped.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			io_rdata_o <= 8'h00;
			io_done_o  <= 1'b0;
		end else begin
			io_rdata_o <= rdata_next;
			io_done_o  <= serial_req || (cyc_state_reg == CYC_RECOVER &&
			                             cyc_cnt_reg == 4'h0);
		end
	end

	// ****************************************************************
	// Shared pins
	// ****************************************************************
	// In serial mode both pins become open-collector: drive only a low.
	always_comb begin
		if (serial_kbd_mode_sel) begin
			sel_data_next    = 1'b0;
			sel_data_oe_next = scan_full && !scan_clear_bit_reg;
			clk_pin_next     = 1'b0;
			clk_pin_oe_next  = !clock_hold_bit_reg;
		end else begin
			sel_data_next    = !(cyc_state_reg == CYC_DELAY ||
			                     cyc_state_reg == CYC_ACTIVE);
			sel_data_oe_next = 1'b1;
			clk_pin_next     = kclk_reg;
			clk_pin_oe_next  = 1'b1;
		end
	end

	// Pins are registered so no decode glitch reaches the board.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			kbd_sel_data_o     <= 1'b1;
			kbd_sel_data_oe_o  <= 1'b1;
			kbd_clock_pin_o    <= 1'b0;
			kbd_clock_pin_oe_o <= 1'b1;
			kbd_ctrl_reset_n_o <= 1'b0;
		end else begin
			kbd_sel_data_o     <= sel_data_next;
			kbd_sel_data_oe_o  <= sel_data_oe_next;
			kbd_clock_pin_o    <= clk_pin_next;
			kbd_clock_pin_oe_o <= clk_pin_oe_next;
			kbd_ctrl_reset_n_o <= 1'b1;
		end
	end

	// ****************************************************************
	// Interrupt and controller return signals
	// ****************************************************************
	// Serial mode ignores the external pins, which a board may leave floating.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			kbd_irq_o            <= 1'b0;
			addr20_gate_o        <= 1'b0;
			cpu_only_reset_req_o <= 1'b0;
		end else if (serial_kbd_mode_sel) begin
			kbd_irq_o            <= scan_full && !scan_clear_bit_reg;
			addr20_gate_o        <= 1'b0;
			cpu_only_reset_req_o <= 1'b0;
		end else begin
			kbd_irq_o            <= kbd_irq_in_i;
			addr20_gate_o        <= addr20_gate_i;
			cpu_only_reset_req_o <= !cpu_only_reset_n_i;
		end
	end

endmodule // kbi_top

`default_nettype wire
